// File: inc/bsa_pkg.sv
`default_nettype none
// ============================================================
// shared constants and types for the bit-sync / gain limit block
package bsa_pkg;

    // ============================================================
    // register addresses on the configuration port
    localparam logic [7:0] BSA_ADDR_BIT_SYNC    = 8'h1a; // bit sync config
    localparam logic [7:0] BSA_ADDR_GAIN_LIMITS = 8'h1b; // agc limits

    // ============================================================
    // reset values
    localparam logic [7:0] BSA_BIT_SYNC_RST    = 8'h6c; // 01 10 1 1 00
    localparam logic [7:0] BSA_GAIN_LIMITS_RST = 8'h03; // goal code 3
    localparam logic [7:0] BSA_RD_UNMAPPED     = 8'h00; // unmapped read

    // ============================================================
    // decode constants
    localparam logic [3:0] BSA_KI_POST_HALVES = 4'h1; // base ki / 2
    localparam logic [2:0] BSA_KP_POST_MULT   = 3'h1; // base kp
    localparam logic [1:0] BSA_SAT_OFF        = 2'h0; // no compensation

    // bit sync config layout, msb first (7:6, 5:4, 3, 2, 1:0)
    typedef struct packed {
        logic [1:0] pre_sync_integral_gain_sel; // ki multiple before sync
        logic [1:0] pre_sync_prop_gain_sel;     // kp multiple before sync
        logic       post_sync_integral_gain_sel; // ki after sync
        logic       post_sync_prop_gain_sel;    // kp after sync
        logic [1:0] rate_offset_saturation;     // data rate offset limit
    } bsa_bit_sync_t;

    // gain limits layout, msb first (7:6, 5:3, 2:0)
    typedef struct packed {
        logic [1:0] digital_gain_ceiling;   // highest digital steps removed
        logic [2:0] front_amp_gain_ceiling; // front amplifier cap code
        logic [2:0] amplitude_goal;         // target amplitude code
    } bsa_gain_limits_t;

    // loop settings handed to the clock recovery loop
    typedef struct packed {
        logic [3:0] integral_halves;  // ki in units of base ki / 2
        logic [2:0] prop_mult;        // kp in units of base kp
        logic       rate_comp_en;     // data rate compensation active
        logic [2:0] rate_limit_32nds; // limit in units of 3.125 percent
    } bsa_loop_gain_t;

    // limits handed to the agc
    typedef struct packed {
        logic [3:0] gain_max_step;       // highest usable digital step
        logic [7:0] front_amp_cut_tenth; // ceiling cut, 0.1 db units
        logic [5:0] amplitude_goal_db;   // target amplitude in db
    } bsa_agc_limits_t;

    // one-hot sync tracking states
    typedef enum logic [1:0] {
        BSA_PRE_SYNC  = 2'b01,
        BSA_POST_SYNC = 2'b10
    } bsa_sync_state_t;

    // rate saturation code to limit in 3.125 percent units
    function automatic logic [2:0] bsa_rate_limit(input logic [1:0] c);
        logic [2:0] r;
        r = 3'h0;
        case (c)
            2'h1: r = 3'h1;
            2'h2: r = 3'h2;
            2'h3: r = 3'h4;
            default: r = 3'h0;
        endcase
        return r;
    endfunction

    // loop gain decode from config and sync phase
    function automatic bsa_loop_gain_t bsa_loop_decode(
        input bsa_bit_sync_t cfg,
        input logic          post
    );
        bsa_loop_gain_t g;
        g.integral_halves  = {1'b0, cfg.pre_sync_integral_gain_sel, 1'b0}
                           + 4'h2;
        g.prop_mult        = {1'b0, cfg.pre_sync_prop_gain_sel} + 3'h1;
        if (post && cfg.post_sync_integral_gain_sel) begin
            g.integral_halves = BSA_KI_POST_HALVES;
        end
        if (post && cfg.post_sync_prop_gain_sel) begin
            g.prop_mult = BSA_KP_POST_MULT;
        end
        g.rate_comp_en     = (cfg.rate_offset_saturation != BSA_SAT_OFF);
        g.rate_limit_32nds = bsa_rate_limit(cfg.rate_offset_saturation);
        return g;
    endfunction

    // front amp ceiling code to cut in tenths of a db
    function automatic logic [7:0] bsa_front_cut(input logic [2:0] c);
        logic [7:0] r;
        r = 8'h00;
        case (c)
            3'h1: r = 8'h1a;  // 2.6 db
            3'h2: r = 8'h3d;  // 6.1 db
            3'h3: r = 8'h4a;  // 7.4 db
            3'h4: r = 8'h5c;  // 9.2 db
            3'h5: r = 8'h73;  // 11.5 db
            3'h6: r = 8'h92;  // 14.6 db
            3'h7: r = 8'hab;  // 17.1 db
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // amplitude goal code to db
    function automatic logic [5:0] bsa_goal_db(input logic [2:0] c);
        logic [5:0] r;
        r = 6'h18;
        case (c)
            3'h1: r = 6'h1b;  // 27 db
            3'h2: r = 6'h1e;  // 30 db
            3'h3: r = 6'h21;  // 33 db
            3'h4: r = 6'h24;  // 36 db
            3'h5: r = 6'h26;  // 38 db
            3'h6: r = 6'h28;  // 40 db
            3'h7: r = 6'h2a;  // 42 db
            default: r = 6'h18; // 24 db
        endcase
        return r;
    endfunction

endpackage
`default_nettype wire

// File: logic/bsa_config.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// [R01] post-sync integral gain: pre value or half base
// [R02] post-sync proportional gain: pre value or base
// [R03] rate offset saturation off or 3.125/6.25/12.5 percent
// [R04] digital gain ceiling removes n highest steps
// [R05] front amp ceiling cut per three-bit code
// [R06] amplitude goal 24 to 42 db, reset code 3
// [R07] pre-sync integral gain one to four times base
// [R08] pre-sync proportional gain one to four times base
// [R09] post gains on sync, pre again on restart

// ============================================================
// bit sync and agc limit configuration registers
module bsa_config #(
    parameter int GAIN_STEPS = 8 // number of digital gain steps
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic [7:0]           reg_addr,
    input  wire logic                 reg_wr_en,
    input  wire logic [7:0]           reg_wr_data,
    input  wire logic                 reg_rd_en,
    output logic [7:0]                reg_rd_data,
    input  wire logic                 sync_detected,
    input  wire logic                 rx_restart,
    output logic                      sync_locked,
    output bsa_pkg::bsa_loop_gain_t   loop_gain,
    output bsa_pkg::bsa_agc_limits_t  agc_limits
);

    // ============================================================
    // register file state
    bsa_pkg::bsa_bit_sync_t    bit_sync_config;          // loop config
    bsa_pkg::bsa_bit_sync_t    next_bit_sync_config;     // its next value
    bsa_pkg::bsa_gain_limits_t gain_control_limits;      // agc limits
    bsa_pkg::bsa_gain_limits_t next_gain_control_limits; // its next value
    logic [7:0]                next_reg_rd_data;         // read data next

    // next register values from the configuration port
    always_comb begin
        next_bit_sync_config     = bit_sync_config;
        next_gain_control_limits = gain_control_limits;
        if (reg_wr_en) begin
            // writes to other addresses are ignored
            if (reg_addr == bsa_pkg::BSA_ADDR_BIT_SYNC) begin
                next_bit_sync_config = reg_wr_data;
            end else if (reg_addr == bsa_pkg::BSA_ADDR_GAIN_LIMITS) begin
                next_gain_control_limits = reg_wr_data;
            end
        end
    end

    // registers hold their documented reset values
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bit_sync_config     <= bsa_pkg::BSA_BIT_SYNC_RST;
            gain_control_limits <= bsa_pkg::BSA_GAIN_LIMITS_RST; // see [R06]
        end else begin
            bit_sync_config     <= next_bit_sync_config;
            gain_control_limits <= next_gain_control_limits;
        end
    end

    // ============================================================
    // read path: registered, one cycle after the strobe
    always_comb begin
        next_reg_rd_data = reg_rd_data;
        if (reg_rd_en) begin
            // unmapped addresses read as zero
            if (reg_addr == bsa_pkg::BSA_ADDR_BIT_SYNC) begin
                next_reg_rd_data = bit_sync_config;
            end else if (reg_addr == bsa_pkg::BSA_ADDR_GAIN_LIMITS) begin
                next_reg_rd_data = gain_control_limits;
            end else begin
                next_reg_rd_data = bsa_pkg::BSA_RD_UNMAPPED;
            end
        end
    end

    // read data register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rd_data <= bsa_pkg::BSA_RD_UNMAPPED;
        end else begin
            reg_rd_data <= next_reg_rd_data;
        end
    end

    // ============================================================
    // sync phase tracking
    bsa_pkg::bsa_sync_state_t sync_state;      // pre or post sync
    bsa_pkg::bsa_sync_state_t next_sync_state; // its next value
    logic                     post_active;     // post gains this cycle

    // sync indication wins over a restart in the same cycle
    always_comb begin
        next_sync_state = sync_state;
        unique case (sync_state)
            bsa_pkg::BSA_PRE_SYNC: begin
                if (sync_detected) begin
                    next_sync_state = bsa_pkg::BSA_POST_SYNC; // see [R09]
                end
            end
            bsa_pkg::BSA_POST_SYNC: begin
                if (rx_restart && !sync_detected) begin
                    next_sync_state = bsa_pkg::BSA_PRE_SYNC; // see [R09]
                end
            end
            default: begin
                next_sync_state = bsa_pkg::BSA_PRE_SYNC;
            end
        endcase
        // selection follows the indication in its own cycle
        post_active = sync_detected
                   || ((sync_state == bsa_pkg::BSA_POST_SYNC)
                       && !rx_restart); // see [R09]
    end

    // state register, pre sync after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync_state <= bsa_pkg::BSA_PRE_SYNC;
        end else begin
            sync_state <= next_sync_state;
        end
    end

    // status: post sync gains in force
    assign sync_locked = (sync_state == bsa_pkg::BSA_POST_SYNC);

    // ============================================================
    // clock recovery loop settings
    bsa_gain_sel u_gain_sel (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .cfg         (bit_sync_config),
        .post_active (post_active),
        .loop_gain   (loop_gain)
    );

    // ============================================================
    // agc limit decode
    bsa_pkg::bsa_agc_limits_t next_agc_limits; // decoded limits

    // decode ceilings and target from the limits register
    always_comb begin
        next_agc_limits.gain_max_step = 4'(GAIN_STEPS - 1)
            - {2'h0, gain_control_limits.digital_gain_ceiling}; // see [R04]
        next_agc_limits.front_amp_cut_tenth = bsa_pkg::bsa_front_cut(
            gain_control_limits.front_amp_gain_ceiling); // see [R05]
        next_agc_limits.amplitude_goal_db = bsa_pkg::bsa_goal_db(
            gain_control_limits.amplitude_goal); // see [R06]
    end

    // registered limits for the agc
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            agc_limits.gain_max_step       <= 4'(GAIN_STEPS - 1);
            agc_limits.front_amp_cut_tenth <= bsa_pkg::bsa_front_cut(
                bsa_pkg::BSA_GAIN_LIMITS_RST[5:3]);
            agc_limits.amplitude_goal_db   <= bsa_pkg::bsa_goal_db(
                bsa_pkg::BSA_GAIN_LIMITS_RST[2:0]);
        end else begin
            agc_limits <= next_agc_limits;
        end
    end

    // ============================================================
    // checks
    AST_POST_KI_HALF: assert property ( // see [R01]
        @(posedge clk) disable iff (sys_rst)
        (sync_detected && bit_sync_config.post_sync_integral_gain_sel)
        |=> (loop_gain.integral_halves == 4'h1))
        else $error("post sync integral gain not half base");

    AST_POST_KP_BASE: assert property ( // see [R02]
        @(posedge clk) disable iff (sys_rst)
        (post_active && bit_sync_config.post_sync_prop_gain_sel)
        |=> (loop_gain.prop_mult == 3'h1))
        else $error("post sync proportional gain not base");

    AST_SAT_OFF: assert property ( // see [R03]
        @(posedge clk) disable iff (sys_rst)
        (bit_sync_config.rate_offset_saturation == 2'h0)
        |=> !loop_gain.rate_comp_en)
        else $error("rate compensation active with saturation off");

    AST_SAT_MAX: assert property ( // see [R03]
        @(posedge clk) disable iff (sys_rst)
        (bit_sync_config.rate_offset_saturation == 2'h3)
        |=> (loop_gain.rate_comp_en && loop_gain.rate_limit_32nds == 3'h4))
        else $error("rate limit not 12.5 percent");

    AST_DIG_CEIL: assert property ( // see [R04]
        @(posedge clk) disable iff (sys_rst)
        (reg_wr_en && reg_addr == bsa_pkg::BSA_ADDR_GAIN_LIMITS
         && reg_wr_data[7:6] == 2'h3)
        |=> ##1 (agc_limits.gain_max_step == 4'(GAIN_STEPS - 4)))
        else $error("three highest digital gain steps not removed");

    AST_FRONT_CUT: assert property ( // see [R05]
        @(posedge clk) disable iff (sys_rst)
        (gain_control_limits.front_amp_gain_ceiling == 3'h7)
        |=> (agc_limits.front_amp_cut_tenth == 8'hab))
        else $error("front amp cut not 17.1 db");

    AST_GOAL_RESET: assert property ( // see [R06]
        @(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> (gain_control_limits.amplitude_goal == 3'h3
                            && agc_limits.amplitude_goal_db == 6'h21))
        else $error("amplitude goal not 33 db after reset");

    AST_PRE_KI: assert property ( // see [R07]
        @(posedge clk) disable iff (sys_rst)
        (!post_active && bit_sync_config.pre_sync_integral_gain_sel == 2'h3)
        |=> (loop_gain.integral_halves == 4'h8))
        else $error("pre sync integral gain not four times base");

    AST_PRE_KP: assert property ( // see [R08]
        @(posedge clk) disable iff (sys_rst)
        (!post_active && bit_sync_config.pre_sync_prop_gain_sel == 2'h0)
        |=> (loop_gain.prop_mult == 3'h1))
        else $error("pre sync proportional gain not base");

    AST_RESTART: assert property ( // see [R09]
        @(posedge clk) disable iff (sys_rst)
        (sync_locked && rx_restart && !sync_detected)
        |=> !sync_locked)
        else $error("restart did not return to pre sync");

    AST_SYNC_LOCK: assert property ( // see [R09]
        @(posedge clk) disable iff (sys_rst)
        sync_detected |=> sync_locked)
        else $error("sync indication not tracked");

endmodule
`default_nettype wire

// File: logic/bsa_gain_sel.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// registered clock recovery loop gain selector
module bsa_gain_sel (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire bsa_pkg::bsa_bit_sync_t  cfg,
    input  wire logic                    post_active,
    output bsa_pkg::bsa_loop_gain_t      loop_gain
);

    bsa_pkg::bsa_loop_gain_t next_loop_gain; // decoded settings

    // decode pre or post sync gains and the saturation point
    always_comb begin
        next_loop_gain = bsa_pkg::bsa_loop_decode(cfg, post_active); // see [R01] [R02] [R03] [R07] [R08]
    end

    // register so the loop sees glitch-free settings
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loop_gain <= bsa_pkg::bsa_loop_decode(
                bsa_pkg::BSA_BIT_SYNC_RST, 1'b0);
        end else begin
            loop_gain <= next_loop_gain;
        end
    end

endmodule
`default_nettype wire

// File: testbench/bitsync_agc_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// self-checking bench for the bit sync and gain limit registers
module bitsync_agc_config_tb;
    localparam int STEPS = 8;          // digital gain steps in this run
    logic                     clk;           // 125 mhz clock
    logic                     sys_rst;       // synchronous reset
    logic                     sync_detected; // sync indication
    logic                     rx_restart;    // restart indication
    logic [7:0]               reg_addr;      // port address
    logic                     reg_wr_en;     // write strobe
    logic [7:0]               reg_wr_data;   // write byte
    logic                     reg_rd_en;     // read strobe
    logic [7:0]               reg_rd_data;   // read byte
    logic                     sync_locked;   // post sync flag
    bsa_pkg::bsa_loop_gain_t  lg;            // loop gains out
    bsa_pkg::bsa_agc_limits_t al;            // agc limits out
    int                       errors;        // mismatches
    int                       tests_run;     // comparisons
    int                       cycles;        // run length guard
    logic [7:0]               cut_tab [8] = '{8'h00, 8'h1a, 8'h3d, 8'h4a,
                                              8'h5c, 8'h73, 8'h92, 8'hab};
    logic [5:0]               goal_tab [8] = '{6'h18, 6'h1b, 6'h1e, 6'h21,
                                               6'h24, 6'h26, 6'h28, 6'h2a};
    logic [2:0]               lim_tab [4] = '{3'h0, 3'h1, 3'h2, 3'h4};

    // ============================================================
    // design, host model and clock
    bsa_config #(.GAIN_STEPS(STEPS)) uut (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .reg_addr      (reg_addr),
        .reg_wr_en     (reg_wr_en),
        .reg_wr_data   (reg_wr_data),
        .reg_rd_en     (reg_rd_en),
        .reg_rd_data   (reg_rd_data),
        .sync_detected (sync_detected),
        .rx_restart    (rx_restart),
        .sync_locked   (sync_locked),
        .loop_gain     (lg),
        .agc_limits    (al)
    );
    bsa_host_model host (
        .clk         (clk),
        .reg_rd_data (reg_rd_data),
        .reg_addr    (reg_addr),
        .reg_wr_en   (reg_wr_en),
        .reg_wr_data (reg_wr_data),
        .reg_rd_en   (reg_rd_en)
    );
    always #4 clk = ~clk;

    // ============================================================
    // shared helpers
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // let n edges pass, then step off the edge
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one-cycle pulse on the sync link, then let outputs settle
    task automatic pulse(input logic s, input logic r);
        @(posedge clk);
        sync_detected <= s;
        rx_restart    <= r;
        @(posedge clk);
        sync_detected <= 1'b0;
        rx_restart    <= 1'b0;
        wait_n(3);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ============================================================
    // scenarios
    // reset values of both registers and their decoded outputs
    task automatic t_reset();
        logic [7:0] d;
        host.rd(8'h1a, d);
        check("bit sync reset", d, 32'h6c);
        host.rd(8'h1b, d);
        check("gain limits reset", d, 32'h03);
        check("goal at reset", al.amplitude_goal_db, 32'h21);
        check("ceiling at reset", al.gain_max_step,
              STEPS - 1);
        check("cut at reset", al.front_amp_cut_tenth, 32'h0);
        check("ki at reset", lg.integral_halves, 32'h4);
        check("kp at reset", lg.prop_mult, 32'h3);
        check("comp at reset", lg.rate_comp_en, 32'h0);
        check("lock at reset", sync_locked, 32'h0);
        $display("test reset done");
    endtask

    // every ceiling, cut and goal code, with readback
    task automatic t_agc();
        logic [2:0] k;
        logic [7:0] v;
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            v = {k[1:0], k, ~k};
            host.wr(8'h1b, v);
            wait_n(3);
            check("ceiling step", al.gain_max_step,
                  STEPS - 1 - int'(k[1:0]));
            check("front cut", al.front_amp_cut_tenth,
                  cut_tab[k]);
            check("goal db", al.amplitude_goal_db,
                  goal_tab[~k]);
            host.rd(8'h1b, d);
            check("limits readback", d, v);
        end
        $display("test agc limits done");
    endtask

    // unmapped address: write ignored, read gives zero
    task automatic t_unmapped();
        logic [7:0] d;
        host.wr(8'h1c, 8'h5a);
        host.rd(8'h1c, d);
        check("unmapped read", d, 32'h0);
        host.rd(8'h1b, d);
        check("limits untouched", d, 32'hf8);
        $display("test unmapped done");
    endtask

    // every pre-sync gain and saturation code
    task automatic t_pre();
        logic [3:0] k;
        for (int i = 0; i < 16; i++) begin
            k = 4'(i);
            host.wr(8'h1a, {k[3:2], k[1:0], 2'b00, k[1:0]});
            wait_n(3);
            check("ki pre", lg.integral_halves,
                  (int'(k[3:2]) + 1) * 2);
            check("kp pre", lg.prop_mult, int'(k[1:0]) + 1);
            check("comp on", lg.rate_comp_en,
                  k[1:0] != 2'h0);
            check("rate limit", lg.rate_limit_32nds,
                  lim_tab[k[1:0]]);
        end
        $display("test pre sync done");
    endtask

    // post-sync selections, restart, and sync beating restart
    task automatic t_sync();
        logic [1:0] k;
        for (int i = 0; i < 4; i++) begin
            k = 2'(i);
            host.wr(8'h1a, {2'b11, 2'b10, k, 2'b01});
            pulse(1'b1, 1'b0);
            check("lock on sync", sync_locked, 32'h1);
            check("ki post", lg.integral_halves, k[1] ? 1 : 8);
            check("kp post", lg.prop_mult, k[0] ? 1 : 3);
            pulse(1'b0, 1'b1);
            check("lock after restart", sync_locked, 32'h0);
            check("ki back to pre", lg.integral_halves, 32'h8);
            check("kp back to pre", lg.prop_mult, 32'h3);
        end
        // lock first, so the joint pulse meets the post state
        pulse(1'b1, 1'b0);
        pulse(1'b1, 1'b1);
        check("sync beats restart", sync_locked, 32'h1);
        check("ki post held", lg.integral_halves, 32'h1);
        check("kp post held", lg.prop_mult, 32'h1);
        // left locked so the next reset must clear the post state
        $display("test sync done");
    endtask

    // ============================================================
    // run guard: a hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            end_of_test();
        end
    end

    // ============================================================
    // main sequence, with a second reset mid-run
    initial begin
        clk           = 1'b0;
        sys_rst       = 1'b1;
        sync_detected = 1'b0;
        rx_restart    = 1'b0;
        errors        = 0;
        tests_run     = 0;
        cycles        = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        wait_n(1);
        t_reset();
        t_agc();
        t_unmapped();
        t_pre();
        t_sync();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        wait_n(1);
        t_reset();
        end_of_test();
    end
endmodule
`default_nettype wire

// File: testbench/bsa_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// host side of the configuration port: single byte reads and writes
module bsa_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rd_data,
    output logic [7:0]      reg_addr,
    output logic            reg_wr_en,
    output logic [7:0]      reg_wr_data,
    output logic            reg_rd_en
);
    // idle port at time zero
    initial begin
        reg_addr    = 8'h00;
        reg_wr_en   = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en   = 1'b0;
    end

    // one write strobe; released lines are scrambled, not held
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr_en   <= 1'b1;
        @(posedge clk);
        reg_wr_en   <= 1'b0;
        reg_addr    <= ~a;
        reg_wr_data <= ~d;
    endtask

    // one read strobe; data is taken once the registered answer lands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        reg_addr  <= ~a;
        @(posedge clk);
        #1;
        d = reg_rd_data;
    endtask
endmodule
`default_nettype wire
